// *** include/exec_pkg.sv ***
// shared constants for the test-skip and table-latch execution block
`default_nettype none
package exec_pkg;
   localparam int unsigned QUARTERS = 4;
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q3 = 2'h2;
   localparam logic [1:0] Q4 = 2'h3;
   // opcode fields: test-skip is 0011 0011 ffff ffff
   localparam logic [7:0] OP_TEST_SKIP = 8'h33;
   // table latch write is 1010 01tx ffff ffff
   localparam logic [5:0] OP_LATCH_WRITE = 6'h29;
   localparam int unsigned SEL_BIT = 9;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] LATCH_RESET = 16'h0000;
   localparam logic [15:0] NOP_WORD = 16'h0000;
   localparam logic [7:0] REG_RESET = 8'h00;
endpackage
`default_nettype wire

// *** hw/reg_file.sv ***
// small register file with registered read data
`default_nettype none
module reg_file (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // read port, data valid one cycle after address
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   // write port
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data
);
   import exec_pkg::*;
   logic [7:0] mem [0:255];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= REG_RESET;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

// *** hw/test_skip_and_latch_exec.sv ***
// quarter-phase execution of the test-skip and table latch write instructions
//
// What this block does
// [RULE1] test_reg_skip_zero skips next only when register zero
// [RULE2] on skip, prefetched instruction discarded, nop run
// [RULE3] one cycle normally, two when skipping, all-nop
// [RULE4] instruction cycle equals four oscillator periods
// [RULE5] external_clock_mode drives quarter clock, period four
// [RULE6] select set writes table_latch_high, low kept
// [RULE7] select clear writes table_latch_low, high kept
`default_nettype none
module test_skip_and_latch_exec (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // fetched instruction, sampled at the end of q4
   input wire logic [15:0] fetch_word,
   // register file write port for loading data
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data,
   // oscillator mode
   input wire logic external_clock_mode,
   // status
   output logic [1:0] quarter,
   output logic fetch_strobe,
   output logic quarter_clock_output,
   output logic skip_cycle,
   output logic skip_taken,
   output logic [7:0] table_latch_high,
   output logic [7:0] table_latch_low,
   output logic [15:0] exec_word
);
   import exec_pkg::*;

   // ----------------------------------------------------------------
   // quarter phase sequencer
   // ----------------------------------------------------------------
   logic [1:0] next_quarter;
   wire cycle_end = (quarter == Q4);
   assign next_quarter = quarter + 2'h1; // [RULE4]

   // reset parks in q4 so the first edge opens a full q1 and the quarter
   // clock starts with a whole high phase instead of a cut one
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         quarter <= Q4;
      end else begin
         quarter <= next_quarter; // [RULE4]
      end
   end

   // quarter clock: high in q1..q2, low in q3..q4, period four clocks
   wire next_qclk = external_clock_mode &&
                    (next_quarter == Q1 || next_quarter == Q2);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         quarter_clock_output <= 1'b0;
      end else begin
         quarter_clock_output <= next_qclk; // [RULE5]
      end
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic logic is_test_skip(input logic [15:0] w);
      is_test_skip = (w[15:8] == OP_TEST_SKIP);
   endfunction

   function automatic logic is_latch_write(input logic [15:0] w);
      is_latch_write = (w[15:10] == OP_LATCH_WRITE);
   endfunction

   wire [7:0] file_addr = exec_word[7:0];
   wire dec_skip = is_test_skip(exec_word) && !skip_cycle;
   wire dec_latch = is_latch_write(exec_word) && !skip_cycle;
   wire latch_sel = exec_word[SEL_BIT];

   // ----------------------------------------------------------------
   // register file, addressed in q1, data ready in q2/q3
   // ----------------------------------------------------------------
   logic [7:0] file_data;

   reg_file reg_file_inst (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .rd_addr(file_addr),
      .rd_data(file_data),
      .wr_en(reg_wr_en),
      .wr_addr(reg_wr_addr),
      .wr_data(reg_wr_data)
   );

   // ----------------------------------------------------------------
   // execute
   // ----------------------------------------------------------------
   wire is_zero = (file_data == ZERO_BYTE);
   wire take_skip = dec_skip && (quarter == Q3) && is_zero; // [RULE1]
   wire latch_wr = dec_latch && (quarter == Q4);
   wire wr_high = latch_wr && latch_sel; // [RULE6]
   wire wr_low = latch_wr && !latch_sel; // [RULE7]

   logic skip_pending;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         skip_pending <= 1'b0;
      end else if (take_skip) begin
         skip_pending <= 1'b1; // [RULE1]
      end else if (cycle_end) begin
         skip_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         skip_taken <= 1'b0;
      end else begin
         skip_taken <= take_skip;
      end
   end

   // prefetched word is replaced by a nop for the following cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         exec_word <= NOP_WORD;
         skip_cycle <= 1'b0;
      end else if (cycle_end) begin
         exec_word <= skip_pending ? NOP_WORD : fetch_word; // [RULE2]
         skip_cycle <= skip_pending; // [RULE3]
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fetch_strobe <= 1'b1;
      end else begin
         fetch_strobe <= (next_quarter == Q4);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         table_latch_high <= LATCH_RESET[15:8];
      end else if (wr_high) begin
         table_latch_high <= file_data; // [RULE6]
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         table_latch_low <= LATCH_RESET[7:0];
      end else if (wr_low) begin
         table_latch_low <= file_data; // [RULE7]
      end
   end
endmodule
`default_nettype wire

// *** testbench/exec_checker.sv ***
// assertions on the test-skip and latch block ports
`default_nettype none
module exec_checker (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // outputs
   input wire logic [1:0] quarter,
   input wire logic fetch_strobe,
   input wire logic quarter_clock_output,
   input wire logic skip_cycle,
   input wire logic skip_taken,
   input wire logic [7:0] table_latch_high,
   input wire logic [7:0] table_latch_low,
   input wire logic [15:0] exec_word
);
   import exec_pkg::*;
   wire lw = exec_word[15:10] == OP_LATCH_WRITE && quarter == Q4;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   zero_test_a: assert property (skip_taken |->
      exec_word[15:8] == OP_TEST_SKIP && quarter == Q4) else $error("skip");
   nop_swap_a: assert property (skip_taken |=>
      skip_cycle && exec_word == NOP_WORD) else $error("no nop");
   skip_len_a: assert property ($rose(skip_cycle) |->
      skip_cycle[*4] ##1 !skip_cycle) else $error("skip length");
   quarter_seq_a: assert property (quarter == Q1 |=> quarter == Q2
      ##1 quarter == Q3 ##1 quarter == Q4 ##1 quarter == Q1) else $error("q");
   fetch_q4_a: assert property (
      fetch_strobe == (quarter == Q4)) else $error("strobe");
   qclk_shape_a: assert property ($rose(quarter_clock_output) |->
      quarter == Q1 ##1 quarter_clock_output ##1 !quarter_clock_output[*2])
      else $error("qclk");
   keep_low_a: assert property (lw && exec_word[SEL_BIT] |=>
      $stable(table_latch_low)) else $error("low hit");
   keep_high_a: assert property (lw && !exec_word[SEL_BIT] |=>
      $stable(table_latch_high)) else $error("high hit");
   cover property (skip_taken);
   cover property (lw && exec_word[SEL_BIT]);
   cover property (lw && !exec_word[SEL_BIT]);
   cover property ($fell(quarter_clock_output) && quarter == Q3);
endmodule
bind test_skip_and_latch_exec exec_checker exec_checker_inst (.*);
`default_nettype wire

// *** testbench/test_skip_and_latch_exec_tb_top.sv ***
// self-checking bench for the test-skip and latch block
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
   bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_skip_and_latch_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import exec_pkg::*;
   logic clk_sys = 0, arst_n = 0, reg_wr_en = 0, external_clock_mode = 1;
   logic [15:0] fetch_word = NOP_WORD;
   logic [7:0] reg_wr_addr = 0, reg_wr_data = 0;
   wire logic [1:0] quarter;
   wire logic fetch_strobe, quarter_clock_output, skip_cycle, skip_taken;
   wire logic [7:0] table_latch_high, table_latch_low;
   wire logic [15:0] exec_word;
   int bad_count = 0, num_checks = 0, cyc = 0;
   test_skip_and_latch_exec test_skip_and_latch_exec_inst (.*);
   always #20 clk_sys = ~clk_sys;
   task automatic issue(input logic [15:0] w);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (quarter !== Q4 && n < 8);
      fetch_word = w;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_sys);
      reg_wr_en = 1;
      reg_wr_addr = a;
      reg_wr_data = d;
      @(negedge clk_sys);
      reg_wr_en = 0;
   endtask
   task automatic skip_test;
      issue(16'h3305);
      issue(16'ha606);
      `CHK("taken", 1'b1, skip_taken)
      `CHK("qclk", 1'b0, quarter_clock_output)
      issue(NOP_WORD);
      `CHK("skip", 1'b1, skip_cycle)
      `CHK("nop", NOP_WORD, exec_word)
      issue(NOP_WORD);
      `CHK("hi", 8'h00, table_latch_high)
      $display("skip test done");
   endtask
   task automatic latch_test;
      issue(16'h3306);
      issue(16'ha406);
      `CHK("taken", 1'b0, skip_taken)
      issue(16'ha607);
      `CHK("exec", 16'ha406, exec_word)
      issue(NOP_WORD);
      `CHK("lo", 8'h5a, table_latch_low)
      `CHK("hi", 8'h00, table_latch_high)
      issue(NOP_WORD);
      `CHK("hi", 8'hc3, table_latch_high)
      `CHK("lo", 8'h5a, table_latch_low)
      $display("latch test done");
   endtask
   task automatic clock_test;
      issue(NOP_WORD);
      `CHK("strobe", 1'b1, fetch_strobe)
      `CHK("qtr", Q4, quarter)
      @(negedge clk_sys);
      `CHK("qclk", 1'b1, quarter_clock_output)
      `CHK("qtr", Q1, quarter)
      `CHK("strobe", 1'b0, fetch_strobe)
      repeat (2) @(negedge clk_sys);
      `CHK("qclk", 1'b0, quarter_clock_output)
      external_clock_mode = 0;
      repeat (4) begin
         @(negedge clk_sys);
         `CHK("qclk off", 1'b0, quarter_clock_output)
      end
      external_clock_mode = 1;
      $display("clock test done");
   endtask
   task automatic end_of_test;
      $display("checks %0d bad %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         end_of_test;
      end
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      arst_n = 1;
      wr(8'h05, 8'h00);
      wr(8'h06, 8'h5a);
      wr(8'h07, 8'hc3);
      skip_test;
      latch_test;
      clock_test;
      end_of_test;
   end
endmodule
`default_nettype wire
